// file: irq_ctrl_pkg.sv
// Overview of operation
// - direction 0: pin input, mask enables it
// - direction 1: pin driven by shared mask
// - remote ack toggles mask in direction 1 only, reads mask back
// - four internal sources, selectable receiver source
// - global enable gates all maskable interrupts
// - exchange op sets, clears or keeps enable
// - return ops restore, set, clear or keep
// - recognition clears global enable
// - five mask bits, one masks source
// - reset sets all five mask bits
// - masking delays service, never discards request
// - fixed priority nmi rx tx turn pin timeout
// - priority re-evaluated at every sample
// - vector is base, zeros, code, zeros
// - fixed three-bit source codes
// - sample each cycle, boundary decides
// - push address, enable, flags, bank; twelve
// - two T-state call, enable cleared early
// - call inserts programmed instruction wait states
// - nmi falling edge latched, cleared on recognition
// - ack changes pin two T-states later
package irq_ctrl_pkg;
    localparam int ADDR_W = 3;
    localparam logic [2:0] IRQ_CTRL_OFS = 3'h0;
    localparam logic [2:0] AUX_CTRL_OFS = 3'h1;
    localparam logic [2:0] VEC_BASE_OFS = 3'h2;
    localparam logic [2:0] WAIT_CFG_OFS = 3'h3;
    localparam logic [2:0] REMOTE_CFG_OFS = 3'h4;
    localparam logic [2:0] COND_CODE_OFS = 3'h5;
    localparam int RXSEL_LSB = 5;
    localparam int DIR_BIT = 0;
    localparam int GIE_BIT = 1;
    localparam int SHARED_BIT = 3;
    localparam logic [4:0] MASK_RST = 5'h1F;
    localparam logic [2:0] CODE_NONE = 3'h0;
    localparam logic [2:0] CODE_NMI = 3'h7;
    localparam logic [2:0] CODE_RX = 3'h1;
    localparam logic [2:0] CODE_TX = 3'h2;
    localparam logic [2:0] CODE_TURN = 3'h3;
    localparam logic [2:0] CODE_PIN = 3'h4;
    localparam logic [2:0] CODE_TO = 3'h5;
    localparam logic [1:0] RXSEL_FULL = 2'h0;
    localparam logic [1:0] RXSEL_DATA = 2'h1;
    localparam logic [1:0] RXSEL_ACTIVE = 2'h2;
    localparam logic [1:0] OPT_KEEP = 2'h0;
    localparam logic [1:0] OPT_CLEAR = 2'h1;
    localparam logic [1:0] OPT_SET = 2'h2;
    localparam logic [1:0] OPT_RESTORE = 2'h3;
    localparam int CLK_PERIOD_NS = 25;
    localparam int TSTATE_NS = 50;
    localparam int TSTATE_CYC = TSTATE_NS / CLK_PERIOD_NS;
    localparam int ACK_DELAY_TSTATES = 2;
    localparam logic [3:0] ACK_DELAY_CYC =
        4'(ACK_DELAY_TSTATES * TSTATE_CYC);
    localparam int STACK_DEPTH = 12;
    localparam int STACK_W = 25;
    typedef enum logic [4:0] {
        ENT_IDLE = 5'h01,
        ENT_T1A = 5'h02,
        ENT_T1B = 5'h04,
        ENT_TW = 5'h08,
        ENT_T2 = 5'h10
    } entry_state_t;
endpackage : irq_ctrl_pkg

// file: stack_if.sv
`timescale 1ns/100ps
interface stack_if;
    import irq_ctrl_pkg::*;
    logic push;
    logic pop;
    logic [STACK_W-1:0] wdata;
    logic [STACK_W-1:0] rdata;
    logic full;
    logic empty;
    modport mem (input push, pop, wdata, output rdata, full, empty);
    modport ctl (output push, pop, wdata, input rdata, full, empty);
endinterface : stack_if

// file: addr_stack.sv
`timescale 1ns/100ps
module addr_stack
    import irq_ctrl_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    stack_if.mem stk
);
    logic [STACK_W-1:0] mem [STACK_DEPTH];
    logic [3:0] sp_r;
    logic [STACK_W-1:0] rdata_r;

    assign stk.rdata = rdata_r;
    assign stk.full = (sp_r == 4'(STACK_DEPTH));
    assign stk.empty = (sp_r == 4'h0);

    // pointer; push wins if both arrive together
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            sp_r <= 4'h0;
        else if (stk.push && !stk.full)
            sp_r <= sp_r + 4'h1;
        else if (stk.pop && !stk.empty)
            sp_r <= sp_r - 4'h1;
    end

    always_ff @(posedge clk)
    begin
        if (stk.push && !stk.full)
            mem[sp_r] <= stk.wdata;
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
            rdata_r <= '0;
        else if (stk.pop && !stk.empty && !stk.push)
            rdata_r <= mem[sp_r - 4'h1];
    end
endmodule : addr_stack

// file: cpu_interrupt_control.sv
`timescale 1ns/100ps
module cpu_interrupt_control
    import irq_ctrl_pkg::*;
#(
    parameter logic [1:0] SEL_FULL = RXSEL_FULL,
    parameter logic [1:0] SEL_DATA = RXSEL_DATA,
    parameter logic [1:0] SEL_ACTIVE = RXSEL_ACTIVE
)
(
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // register port
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdata,
    // remote side
    input wire logic remoteAckWr,
    input wire logic remoteAckData,
    output logic remoteAckRead,
    // pins
    input wire logic nmiPin_n,
    input wire logic sharedIrqPinIn,
    output logic sharedIrqPinOut,
    output logic sharedIrqPinOe,
    // transceiver sources
    input wire logic txQueueEmptyIrq,
    input wire logic lineTurnaroundIrq,
    input wire logic timeoutIrq,
    input wire logic rxQueueFullIrq,
    input wire logic rxDataAvailableIrq,
    input wire logic rxActiveIrq,
    // cpu timing
    input wire logic instrStart,
    input wire logic [15:0] pcIn,
    input wire logic [3:0] flagsIn,
    input wire logic [3:0] bankIn,
    input wire logic bankExchangeOp,
    input wire logic [1:0] bankExchangeOpt,
    input wire logic returnOp,
    input wire logic [1:0] returnOpt,
    // entry and return results
    output logic irqTaken,
    output logic callBusy,
    output logic [15:0] vectorAddr,
    output logic retValid,
    output logic [15:0] retAddr,
    output logic [3:0] retFlags,
    output logic [3:0] retBank
);
    stack_if stk ();
    addr_stack u_stack (.clk(clk), .reset_n(reset_n), .stk(stk));

    logic [4:0] irqMask_r;
    logic [1:0] rxSel_r;
    logic pinDir_r;
    logic gie_r;
    logic [7:0] vecBase_r;
    logic [2:0] waitCfg_r;
    logic ccPin_r;
    logic [7:0] regRdata_r;
    logic remoteAckRead_r;
    logic pinOut_r;
    logic pinOe_r;
    logic [3:0] ackCnt_r;
    logic nmiLatch_r;
    logic nmiPrev_r;
    entry_state_t entState_r;
    logic [3:0] entCnt_r;
    logic irqTaken_r;
    logic callBusy_r;
    logic [15:0] vectorAddr_r;
    logic popPend_r;
    logic [1:0] popOpt_r;
    logic retValid_r;
    logic [15:0] retAddr_r;
    logic [3:0] retFlags_r;
    logic [3:0] retBank_r;
    logic [1:0] syncIn;
    logic [1:0] pinFlt;
    logic rxSrc;
    logic [5:0] reqs;
    logic [2:0] winCode;
    logic take;
    logic icrWr;
    logic acrWr;
    logic ackAccept;

    // pin synchronisers: three stages, filtered on agreement
    assign syncIn = {nmiPin_n, sharedIrqPinIn};
    generate
        for (genvar i = 0; i < 2; i++)
        begin : g_sync
            logic s1_r;
            logic s2_r;
            logic s3_r;
            logic flt_r;
            always_ff @(posedge clk)
            begin
                if (!reset_n)
                begin
                    s1_r <= 1'b1;
                    s2_r <= 1'b1;
                    s3_r <= 1'b1;
                    flt_r <= 1'b1;
                end
                else
                begin
                    s1_r <= syncIn[i];
                    s2_r <= s1_r;
                    s3_r <= s2_r;
                    if (s2_r == s3_r)
                        flt_r <= s3_r;
                end
            end
            assign pinFlt[i] = flt_r;
        end
    endgenerate

    function automatic logic [2:0] pickCode(input logic [5:0] r);
        // order: nmi, rx, tx, turnaround, shared pin, timeout
        if (r[5])
            return CODE_NMI;
        else if (r[4])
            return CODE_RX;
        else if (r[3])
            return CODE_TX;
        else if (r[2])
            return CODE_TURN;
        else if (r[1])
            return CODE_PIN;
        else if (r[0])
            return CODE_TO;
        else
            return CODE_NONE;
    endfunction : pickCode

    assign icrWr = regWr && (regAddr == IRQ_CTRL_OFS);
    assign acrWr = regWr && (regAddr == AUX_CTRL_OFS);
    assign ackAccept = remoteAckWr && remoteAckData && pinDir_r;

    always_comb
    begin
        if (rxSel_r == SEL_FULL)
            rxSrc = rxQueueFullIrq;
        else if (rxSel_r == SEL_DATA)
            rxSrc = rxDataAvailableIrq;
        else if (rxSel_r == SEL_ACTIVE)
            rxSrc = rxActiveIrq;
        else
            rxSrc = 1'b0;
    end

    assign reqs = {nmiLatch_r,
        {5{gie_r}} & ~{irqMask_r[0], irqMask_r[1], irqMask_r[2],
        irqMask_r[3], irqMask_r[4]} &
        {rxSrc, txQueueEmptyIrq, lineTurnaroundIrq,
        !pinDir_r && !pinFlt[0], timeoutIrq}};
    assign winCode = pickCode(reqs);
    assign take = instrStart && (entState_r == ENT_IDLE)
        && (winCode != CODE_NONE);

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            irqMask_r <= MASK_RST;
            rxSel_r <= RXSEL_FULL;
        end
        else if (icrWr)
        begin
            irqMask_r <= regWdata[4:0];
            rxSel_r <= regWdata[RXSEL_LSB +: 2];
        end
        // toggle; a local write the same cycle wins
        else if (ackCnt_r == 4'h1 && pinDir_r)
            irqMask_r[SHARED_BIT] <= !irqMask_r[SHARED_BIT];
    end

    // two T-state delay before the toggle
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            ackCnt_r <= 4'h0;
        else if (ackAccept)
            ackCnt_r <= ACK_DELAY_CYC - 4'h1;
        else if (ackCnt_r != 4'h0)
            ackCnt_r <= ackCnt_r - 4'h1;
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            pinDir_r <= 1'b0;
            vecBase_r <= 8'h00;
            waitCfg_r <= 3'h0;
        end
        else
        begin
            if (acrWr)
                pinDir_r <= regWdata[DIR_BIT];
            if (regWr && regAddr == VEC_BASE_OFS)
                vecBase_r <= regWdata;
            if (regWr && regAddr == WAIT_CFG_OFS)
                waitCfg_r <= regWdata[2:0];
        end
    end

    // pin follows shared mask in output mode
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            pinOut_r <= 1'b1;
            pinOe_r <= 1'b0;
            ccPin_r <= 1'b1;
            remoteAckRead_r <= 1'b1;
        end
        else
        begin
            pinOut_r <= irqMask_r[SHARED_BIT];
            pinOe_r <= pinDir_r;
            remoteAckRead_r <= irqMask_r[SHARED_BIT];
            // status mirrors the pin at each instruction start
            if (instrStart)
                ccPin_r <= pinFlt[0];
        end
    end

    // nmi falling edge; set wins over clear
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            nmiPrev_r <= 1'b1;
            nmiLatch_r <= 1'b0;
        end
        else
        begin
            nmiPrev_r <= pinFlt[1];
            if (nmiPrev_r && !pinFlt[1])
                nmiLatch_r <= 1'b1;
            else if (take && winCode == CODE_NMI)
                nmiLatch_r <= 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            entState_r <= ENT_IDLE;
            entCnt_r <= 4'h0;
        end
        else
        begin
            case (entState_r)
                ENT_IDLE:
                    if (take)
                        entState_r <= ENT_T1A;
                ENT_T1A:
                    entState_r <= ENT_T1B;
                ENT_T1B:
                begin
                    entCnt_r <= 4'(waitCfg_r) * 4'(TSTATE_CYC);
                    entState_r <= (waitCfg_r == 3'h0) ? ENT_T2 : ENT_TW;
                end
                ENT_TW:
                begin
                    entCnt_r <= entCnt_r - 4'h1;
                    if (entCnt_r == 4'h1)
                    begin
                        entCnt_r <= 4'(TSTATE_CYC);
                        entState_r <= ENT_T2;
                    end
                end
                ENT_T2:
                begin
                    entCnt_r <= entCnt_r - 4'h1;
                    if (entCnt_r <= 4'h1)
                        entState_r <= ENT_IDLE;
                end
                default:
                    entState_r <= ENT_IDLE;
            endcase
            if (entState_r == ENT_T1B && waitCfg_r == 3'h0)
                entCnt_r <= 4'(TSTATE_CYC);
        end
    end

    // vector formed in the first half of T1
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            vectorAddr_r <= 16'h0000;
            irqTaken_r <= 1'b0;
            callBusy_r <= 1'b0;
        end
        else
        begin
            irqTaken_r <= take;
            callBusy_r <= take || (entState_r != ENT_IDLE &&
                !(entState_r == ENT_T2 && entCnt_r <= 4'h1));
            if (take)
                vectorAddr_r <= {vecBase_r, 3'h0, winCode, 2'h0};
        end
    end

    // push on recognition, pop on return
    assign stk.push = take;
    assign stk.wdata = {pcIn, gie_r, flagsIn, bankIn};
    assign stk.pop = returnOp;

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            popPend_r <= 1'b0;
            popOpt_r <= OPT_KEEP;
        end
        else
        begin
            popPend_r <= returnOp && !stk.empty && !take;
            popOpt_r <= returnOpt;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            retValid_r <= 1'b0;
            retAddr_r <= 16'h0000;
            retFlags_r <= 4'h0;
            retBank_r <= 4'h0;
        end
        else
        begin
            retValid_r <= popPend_r;
            if (popPend_r)
            begin
                retAddr_r <= stk.rdata[24:9];
                retFlags_r <= stk.rdata[7:4];
                retBank_r <= stk.rdata[3:0];
            end
        end
    end

    // global enable; entry clear beats everything else
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            gie_r <= 1'b0;
        // cleared at end of first half of T1
        else if (entState_r == ENT_T1A)
            gie_r <= 1'b0;
        else if (acrWr)
            gie_r <= regWdata[GIE_BIT];
        else if (popPend_r && popOpt_r == OPT_RESTORE)
            gie_r <= stk.rdata[8];
        else if (returnOp && returnOpt == OPT_SET)
            gie_r <= 1'b1;
        else if (returnOp && returnOpt == OPT_CLEAR)
            gie_r <= 1'b0;
        else if (bankExchangeOp && bankExchangeOpt == OPT_SET)
            gie_r <= 1'b1;
        else if (bankExchangeOp && bankExchangeOpt == OPT_CLEAR)
            gie_r <= 1'b0;
    end

    // register reads, data in the following cycle
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            regRdata_r <= 8'h00;
        else if (regRd)
        begin
            case (regAddr)
                IRQ_CTRL_OFS:
                    regRdata_r <= {1'b0, rxSel_r, irqMask_r};
                AUX_CTRL_OFS:
                    regRdata_r <= {6'h00, gie_r, pinDir_r};
                VEC_BASE_OFS:
                    regRdata_r <= vecBase_r;
                WAIT_CFG_OFS:
                    regRdata_r <= {5'h00, waitCfg_r};
                REMOTE_CFG_OFS:
                    regRdata_r <= {7'h00, irqMask_r[SHARED_BIT]};
                COND_CODE_OFS:
                    regRdata_r <= {7'h00, ccPin_r};
                default:
                    regRdata_r <= 8'h00;
            endcase
        end
    end

    assign regRdata = regRdata_r;
    assign remoteAckRead = remoteAckRead_r;
    assign sharedIrqPinOut = pinOut_r;
    assign sharedIrqPinOe = pinOe_r;
    assign irqTaken = irqTaken_r;
    assign callBusy = callBusy_r;
    assign vectorAddr = vectorAddr_r;
    assign retValid = retValid_r;
    assign retAddr = retAddr_r;
    assign retFlags = retFlags_r;
    assign retBank = retBank_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    AST_MASK_RESET: assert property (
        $past(!reset_n) |-> irqMask_r == MASK_RST)
        else $error("masks not set after reset");
    AST_PIN_DRIVE: assert property (
        pinDir_r |=> sharedIrqPinOe &&
        sharedIrqPinOut == $past(irqMask_r[SHARED_BIT]))
        else $error("pin not driven by shared mask");
    // restarted or overridden acks are left out of the antecedent
    AST_ACK_DELAY: assert property (
        ackAccept ##1 (!icrWr && pinDir_r && !ackAccept)[*3] |->
        ##2 sharedIrqPinOut != $past(sharedIrqPinOut))
        else $error("pin did not change after ack");
    AST_GIE_CLEAR: assert property (
        take |-> ##2 !gie_r)
        else $error("enable not cleared on entry");
    AST_VECTOR: assert property (
        take |=> vectorAddr_r[15:8] == $past(vecBase_r)
        && vectorAddr_r[7:5] == 3'h0 && vectorAddr_r[1:0] == 2'h0)
        else $error("vector layout wrong");
    AST_NMI_FIRST: assert property (
        take && nmiLatch_r |=> vectorAddr_r[4:2] == CODE_NMI)
        else $error("nmi not highest priority");
    AST_GLOBAL: assert property (
        take |-> gie_r || winCode == CODE_NMI)
        else $error("maskable taken while disabled");
    AST_NMI_CLEAR: assert property (
        take && winCode == CODE_NMI && !(nmiPrev_r && !pinFlt[1])
        |=> !nmiLatch_r)
        else $error("nmi latch not cleared");
    AST_NO_ACK_INPUT: assert property (
        remoteAckWr && !pinDir_r && !icrWr && ackCnt_r == 4'h0
        |=> $stable(irqMask_r))
        else $error("ack acted in input mode");

    COV_TAKE: cover property (take);
    COV_NMI: cover property (take && winCode == CODE_NMI);
    COV_ACK: cover property (ackAccept ##4 1'b1);
    COV_RET: cover property (retValid_r);
endmodule : cpu_interrupt_control

// file: remote_host.sv
`timescale 1ns/100ps
module remote_host
(
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // commands from the bench
    input wire logic holdReq,
    input wire logic ackReq,
    // device side
    input wire logic irqSeen,
    input wire logic pinOut,
    input wire logic pinOe,
    output logic pinLevel,
    output logic ackWr,
    output logic ackData
);
    logic holdLow_r;

    always_ff @(posedge clk)
    begin
        if (!reset_n || irqSeen)
            holdLow_r <= 1'b0;
        else if (holdReq)
            holdLow_r <= 1'b1;
    end

    // ack is a write of one
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            ackWr <= 1'b0;
            ackData <= 1'b0;
        end
        else
        begin
            ackWr <= ackReq;
            // idle data wanders so a stale bit is never trusted
            ackData <= ackReq ? 1'b1 : ~ackData;
        end
    end

    assign pinLevel = pinOe ? pinOut : ~holdLow_r;
endmodule : remote_host

// file: tb_top.sv
`timescale 1ns/100ps
`define CHK(g, e, m) \
    begin \
        samples_checked++; \
        if ((g) !== (e)) \
        begin \
            n_fail++; \
            $display("mismatch at %0t: %s", $time, m); \
        end \
    end
module tb_top
    import irq_ctrl_pkg::*;
;
    localparam logic [7:0] BASE = 8'hA5;
    localparam logic [2:0] CODES [4] = '{CODE_RX, CODE_TX, CODE_TURN, CODE_TO};
    localparam logic [1:0] SELS [3] = '{RXSEL_FULL, RXSEL_DATA, RXSEL_ACTIVE};
    localparam logic [1:0] XOPT [3] = '{OPT_SET, OPT_KEEP, OPT_CLEAR};
    localparam logic [7:0] XEXP [3] = '{8'h02, 8'h02, 8'h00};
    logic clk = 1'b0;
    logic reset_n, regWr, regRd, remoteAckWr, remoteAckData, remoteAckRead;
    logic [2:0] regAddr;
    logic [7:0] regWdata, regRdata, d;
    logic nmiPin_n, pinIn, pinOut, pinOe, tx, turn, tmo, rxFull, rxData, rxAct;
    logic instrStart, xchOp, retOp, irqTaken, callBusy, retValid;
    logic holdReq, ackReq;
    logic [15:0] pcIn, vectorAddr, retAddr, pc;
    logic [3:0] retFlags, retBank;
    logic [1:0] xchOpt, retOpt;
    int n_fail = 0;
    int samples_checked = 0;
    int len0, len;

    always #12.5 clk = ~clk;

    cpu_interrupt_control dut_u (.clk(clk), .reset_n(reset_n),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .remoteAckWr(remoteAckWr),
        .remoteAckData(remoteAckData), .remoteAckRead(remoteAckRead),
        .nmiPin_n(nmiPin_n), .sharedIrqPinIn(pinIn), .sharedIrqPinOut(pinOut),
        .sharedIrqPinOe(pinOe), .txQueueEmptyIrq(tx),
        .lineTurnaroundIrq(turn), .timeoutIrq(tmo), .rxQueueFullIrq(rxFull),
        .rxDataAvailableIrq(rxData), .rxActiveIrq(rxAct),
        .instrStart(instrStart), .pcIn(pcIn), .flagsIn(4'hA), .bankIn(4'h5),
        .bankExchangeOp(xchOp), .bankExchangeOpt(xchOpt), .returnOp(retOp),
        .returnOpt(retOpt), .irqTaken(irqTaken), .callBusy(callBusy),
        .vectorAddr(vectorAddr), .retValid(retValid), .retAddr(retAddr),
        .retFlags(retFlags), .retBank(retBank));

    remote_host host_u (.clk(clk), .reset_n(reset_n), .holdReq(holdReq),
        .ackReq(ackReq), .irqSeen(irqTaken), .pinOut(pinOut), .pinOe(pinOe),
        .pinLevel(pinIn), .ackWr(remoteAckWr), .ackData(remoteAckData));

    task finish_test;
        if (n_fail == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : finish_test

    task wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk);
        regAddr <= a;
        regWdata <= v;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask : wr

    task rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1 v = regRdata;
    endtask : rd

    task take(input logic [2:0] code, input logic [15:0] p);
        @(posedge clk);
        instrStart <= 1'b1;
        pcIn <= p;
        @(posedge clk);
        instrStart <= 1'b0;
        #1;
        `CHK(irqTaken, 1'b1, "no entry")
        `CHK(vectorAddr, {BASE, 3'b000, code, 2'b00}, "vector")
        len = 0;
        // bounded so a stuck call ends the run
        while (callBusy === 1'b1 && len < 50)
        begin
            @(posedge clk);
            #1 len++;
        end
        if (len >= 50)
        begin
            n_fail++;
            finish_test();
        end
    endtask : take

    task noTake;
        @(posedge clk);
        instrStart <= 1'b1;
        @(posedge clk);
        instrStart <= 1'b0;
        #1;
        `CHK(irqTaken, 1'b0, "unexpected entry")
    endtask : noTake

    task ret(input logic [1:0] opt, input logic [15:0] p);
        @(posedge clk);
        retOp <= 1'b1;
        retOpt <= opt;
        @(posedge clk);
        retOp <= 1'b0;
        @(posedge clk);
        #1;
        `CHK(retValid, 1'b1, "no return")
        `CHK({retAddr, retFlags, retBank}, {p, 8'hA5}, "return data")
    endtask : ret

    task xch(input logic [1:0] opt);
        @(posedge clk);
        xchOp <= 1'b1;
        xchOpt <= opt;
        @(posedge clk);
        xchOp <= 1'b0;
    endtask : xch

    task ack(input logic b, input logic a);
        @(posedge clk);
        ackReq <= 1'b1;
        @(posedge clk);
        ackReq <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        `CHK(remoteAckRead, b, "ack too early")
        repeat (2) @(posedge clk);
        #1;
        `CHK(remoteAckRead, a, "ack readback")
    endtask : ack

    initial
    begin
        repeat (60000) @(posedge clk);
        n_fail++;
        finish_test();
    end

    initial
    begin
        {reset_n, regWr, regRd, instrStart, xchOp, retOp} = '0;
        {tx, turn, tmo, rxFull, rxData, rxAct, holdReq, ackReq} = '0;
        {regAddr, regWdata, xchOpt, retOpt, pcIn} = '0;
        nmiPin_n = 1'b1;
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        rd(IRQ_CTRL_OFS, d);
        `CHK(d, 8'h1F, "mask reset")
        rd(AUX_CTRL_OFS, d);
        `CHK(d, 8'h00, "aux reset")
        `CHK({pinOe, pinOut, remoteAckRead}, 3'b011, "pin reset")
        wr(3'h7, 8'hFF);
        rd(3'h7, d);
        `CHK(d, 8'h00, "unmapped")
        wr(VEC_BASE_OFS, BASE);
        wr(AUX_CTRL_OFS, 8'h02);
        {tx, turn, tmo, rxFull} <= 4'hF;
        noTake();
        wr(IRQ_CTRL_OFS, 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            pc = 16'h1000 + 16'(i);
            take(CODES[i], pc);
            if (i == 0)
                len0 = len;
            rd(AUX_CTRL_OFS, d);
            `CHK(d, 8'h00, "enable not cleared")
            case (i)
                0: rxFull <= 1'b0;
                1: tx <= 1'b0;
                2: turn <= 1'b0;
                default: tmo <= 1'b0;
            endcase
            ret(OPT_RESTORE, pc);
            rd(AUX_CTRL_OFS, d);
            `CHK(d, 8'h02, "enable not restored")
        end
        wr(AUX_CTRL_OFS, 8'h00);
        @(posedge clk);
        nmiPin_n <= 1'b0;
        repeat (4) @(posedge clk);
        take(CODE_NMI, 16'h2000);
        ret(OPT_KEEP, 16'h2000);
        noTake();
        nmiPin_n <= 1'b1;
        tmo <= 1'b1;
        noTake();
        for (int i = 0; i < 3; i++)
        begin
            xch(XOPT[i]);
            rd(AUX_CTRL_OFS, d);
            `CHK(d, XEXP[i], "exchange option")
        end
        xch(OPT_SET);
        wr(WAIT_CFG_OFS, 8'h02);
        take(CODE_TO, 16'h3000);
        `CHK(len - len0, 2 * TSTATE_CYC, "wait states")
        tmo <= 1'b0;
        ret(OPT_RESTORE, 16'h3000);
        // only the selected receiver source counts
        for (int s = 0; s < 3; s++)
        begin
            wr(IRQ_CTRL_OFS, {1'b0, SELS[s], 5'h1E});
            {rxFull, rxData, rxAct} <= ~(3'b100 >> s);
            noTake();
            {rxFull, rxData, rxAct} <= 3'b111;
            take(CODE_RX, 16'h5000);
            {rxFull, rxData, rxAct} <= 3'b000;
            ret(OPT_RESTORE, 16'h5000);
        end
        wr(IRQ_CTRL_OFS, 8'h7E);
        {rxFull, rxData, rxAct} <= 3'b111;
        noTake();
        {rxFull, rxData, rxAct} <= 3'b000;
        wr(IRQ_CTRL_OFS, 8'h17);
        holdReq <= 1'b1;
        @(posedge clk);
        holdReq <= 1'b0;
        ack(1'b0, 1'b0);
        repeat (6) @(posedge clk);
        take(CODE_PIN, 16'h4000);
        ret(OPT_RESTORE, 16'h4000);
        repeat (8) @(posedge clk);
        noTake();
        wr(AUX_CTRL_OFS, 8'h01);
        wr(IRQ_CTRL_OFS, 8'h1F);
        repeat (2) @(posedge clk);
        #1;
        `CHK({pinOe, pinOut}, 2'b11, "pin drive")
        ack(1'b1, 1'b0);
        `CHK(pinOut, 1'b0, "pin after ack")
        rd(REMOTE_CFG_OFS, d);
        `CHK(d[0], 1'b0, "ack bit readback")
        // pin filter lags the pin by four edges
        repeat (4) @(posedge clk);
        noTake();
        rd(COND_CODE_OFS, d);
        `CHK(d[0], 1'b0, "pin status")
        ack(1'b0, 1'b1);
        `CHK(pinOut, 1'b1, "pin after second ack")
        finish_test();
    end
endmodule : tb_top
